// ---- rcdb_defs.vh ----
// Purpose: constants for the reclose dynamic blocking supervisor
// Assumes: 125 MHz clock, 8 ns period
// Notes:   times in ms, counts derived in cycles
`ifndef RCDB_DEFS_VH
`define RCDB_DEFS_VH
`define RCDB_CLK_KHZ        125000
`define RCDB_BLOCK_MS       500
`define RCDB_BLOCK_CYC      (`RCDB_BLOCK_MS * `RCDB_CLK_KHZ)
`define RCDB_TMR_W          32
// register byte addresses
`define RCDB_A_CTRL         12'h000
`define RCDB_A_ACT_T        12'h004
`define RCDB_A_WATCH_T      12'h008
`define RCDB_A_EXT_T        12'h00c
`define RCDB_A_RDY_T        12'h010
`define RCDB_A_MC_T         12'h014
`define RCDB_A_ILIM         12'h018
`define RCDB_A_STAT         12'h01c
`define RCDB_A_IRQ_ST       12'h020
`define RCDB_A_IRQ_MASK     12'h024
// control fields
`define RCDB_C_RDYCHK       0
`define RCDB_C_REVEN        1
`define RCDB_CTRL_RST       32'h0000_0000
// event bits in irq status / mask
`define RCDB_EV_W           12
`define RCDB_EV_ACT         0
`define RCDB_EV_WATCH       1
`define RCDB_EV_EXT         2
`define RCDB_EV_RDY         3
`define RCDB_EV_RECLAIM     4
`define RCDB_EV_REV         5
`define RCDB_EV_ILIM        6
`define RCDB_EV_THERM       7
`define RCDB_EV_LOCK        8
`define RCDB_EV_BF          9
`define RCDB_EV_MC          10
`define RCDB_EV_EXTBLK      11
`endif

// ---- rcdb_top.v ----
// Purpose: places the reclose function into timed dynamic block on fault causes
// Assumes: all inputs synchronous to clk; settings reached over apb
// Notes:   reclose sequencing lives outside; this block only supervises it
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "rcdb_defs.vh"

// Function
// - trip after action time expiry but before pickup reset forces dynamic block
// - trip-to-open watch timer expiry before breaker opens forces dynamic block
// - dead time end starts extension limit timer; its expiry forces block
// - with ready check chosen, ready loss in dead time starts watch; expiry blocks 500 ms
// - reclaim or close-command time expiry with breaker open blocks
// - pickup with reverse block enabled and reverse fault blocks reclosing
// - fault current at block limit blocks a started sequence for 500 ms
// - other protection trip during thermal reclose blocks until timer ends
// - trip within reclaim after last attempt used blocks 500 ms
// - lockout flag when no cycles remain; separate breaker-failure flag
// - trip while statically blocked gives no indication at all
// - manual close block time zero ignores manual close; nonzero blocks
// - nonzero time blocks on manual close even unstarted or statically blocked
// - manual close starts its block timer and the 500 ms timer together
// - block timer expiry with manual close timer running restarts the block
// - on block timer expiry return to normal only if no cause remains
// - breaker-failure trip blocks regardless of cycle count, asserts block flag
// - external block input blocks reclosing and is echoed as indication
module rcdb_top (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // protection and breaker inputs
  input  wire        prot_pickup,
  input  wire        prot_trip,
  input  wire        bf_trip,
  input  wire        thermal_ar_active,
  input  wire        other_prot_trip,
  input  wire        reverse_fault,
  input  wire [15:0] fault_current,
  input  wire        breaker_open,
  input  wire        breaker_closed,
  input  wire        breaker_ready_input,
  input  wire        external_block_input,
  input  wire        manual_close_detect,
  // sequencer status
  input  wire        seq_started,
  input  wire        dead_time_end,
  input  wire        in_dead_time,
  input  wire        reclaim_running,
  input  wire        reclaim_expired,
  input  wire        cycles_exhausted,
  input  wire        static_block,
  // indications
  output reg         dynamic_block_flag,
  output reg         reclose_lockout_flag,
  output reg         breaker_fail_block_flag,
  output reg         external_block_echo,
  output wire        irq
);

  localparam ST_NORMAL = 2'b01;
  localparam ST_BLOCK  = 2'b10;
  localparam [31:0] BLOCK_CYC = `RCDB_BLOCK_CYC;

  reg [1:0]  state_r;
  reg [31:0] ctrl_r;
  reg [31:0] act_t_r, watch_t_r, ext_t_r, rdy_t_r, mc_t_r;
  reg [15:0] ilim_r;
  reg [`RCDB_EV_W-1:0] irq_st_r, irq_mask_r;
  reg [31:0] blk_cnt_r;
  reg [31:0] mc_cnt_r;
  reg        prot_trip_d_r, mc_d_r, pickup_d_r, rdy_d_r, dte_d_r;
  reg        prot_trip_armed_r;

  // one-shot timers: act, watch, ext, rdy
  reg  [3:0]  tmr_run_r;
  reg  [31:0] tmr_cnt_r [0:3];
  wire [3:0]  tmr_start;
  wire [3:0]  tmr_stop;
  wire [3:0]  tmr_exp;
  wire [31:0] tmr_lim [0:3];

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function addr_hit;
    input [11:0] a;
    input [11:0] base;
    begin
      addr_hit = (a[11:2] == base[11:2]);
    end
  endfunction

  wire trip_rise   = prot_trip & ~prot_trip_d_r;
  wire pickup_rise = prot_pickup & ~pickup_d_r;
  wire mc_rise     = manual_close_detect & ~mc_d_r;
  wire rdy_fall    = ~breaker_ready_input & rdy_d_r;
  wire dte_rise    = dead_time_end & ~dte_d_r;
  wire mc_en       = (mc_t_r != 32'h0000_0000);
  wire mc_running  = (mc_cnt_r != 32'h0000_0000);

  assign tmr_lim[0] = act_t_r;
  assign tmr_lim[1] = watch_t_r;
  assign tmr_lim[2] = ext_t_r;
  assign tmr_lim[3] = rdy_t_r;
  assign tmr_start[0] = pickup_rise;
  assign tmr_stop[0]  = ~prot_pickup;
  assign tmr_start[1] = trip_rise & ~static_block;
  assign tmr_stop[1]  = breaker_open;
  assign tmr_start[2] = dte_rise;
  assign tmr_stop[2]  = breaker_closed | ~seq_started;
  assign tmr_start[3] = rdy_fall & in_dead_time & ctrl_r[`RCDB_C_RDYCHK];
  assign tmr_stop[3]  = breaker_ready_input;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_tmr
      assign tmr_exp[gi] = tmr_run_r[gi] & (tmr_cnt_r[gi] >= tmr_lim[gi]);
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tmr_run_r[gi] <= 1'b0;
          tmr_cnt_r[gi] <= 32'h0000_0000;
        end else if (tmr_start[gi]) begin
          tmr_run_r[gi] <= 1'b1;
          tmr_cnt_r[gi] <= 32'h0000_0000;
        end else if (tmr_stop[gi] | tmr_exp[gi]) begin
          tmr_run_r[gi] <= 1'b0;
        end else if (tmr_run_r[gi]) begin
          tmr_cnt_r[gi] <= tmr_cnt_r[gi] + 32'h0000_0001;
        end
      end
    end
  endgenerate

  // action time stays expired until pickup resets
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_trip_armed_r <= 1'b0;
    end else if (~prot_pickup | pickup_rise) begin
      prot_trip_armed_r <= 1'b0;
    end else if (tmr_exp[0]) begin
      prot_trip_armed_r <= 1'b1;
    end
  end

  // cause vector; static block suppresses trip-born causes
  reg [`RCDB_EV_W-1:0] ev;
  always @* begin
    ev = {`RCDB_EV_W{1'b0}};
    ev[`RCDB_EV_ACT]     = trip_rise & prot_trip_armed_r & ~static_block;
    ev[`RCDB_EV_WATCH]   = tmr_exp[1] & ~breaker_open;
    ev[`RCDB_EV_EXT]     = tmr_exp[2] & ~breaker_closed;
    ev[`RCDB_EV_RDY]     = tmr_exp[3] & ~breaker_ready_input;
    ev[`RCDB_EV_RECLAIM] = reclaim_expired & ~breaker_closed;
    ev[`RCDB_EV_REV]     = prot_pickup & reverse_fault & ctrl_r[`RCDB_C_REVEN];
    ev[`RCDB_EV_ILIM]    = seq_started & (fault_current >= ilim_r);
    ev[`RCDB_EV_THERM]   = thermal_ar_active & other_prot_trip;
    ev[`RCDB_EV_LOCK]    = cycles_exhausted & reclaim_running & trip_rise
                           & ~static_block;
    ev[`RCDB_EV_BF]      = bf_trip;
    ev[`RCDB_EV_MC]      = mc_rise & mc_en;
    ev[`RCDB_EV_EXTBLK]  = external_block_input;
  end

  // level causes that keep the block in force at expiry
  wire hold_cause = external_block_input | mc_running | bf_trip
                    | (thermal_ar_active & other_prot_trip);
  wire any_ev   = |ev;
  wire blk_exp  = (state_r == ST_BLOCK) & (blk_cnt_r == 32'h0000_0000);
  // next value of the block flag; sticky flags fall with it, never after it
  wire dyn_nxt  = any_ev | ((state_r == ST_BLOCK) & ~(blk_exp & ~hold_cause));

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_NORMAL;
      blk_cnt_r <= 32'h0000_0000;
    end else begin
      case (state_r)
        ST_NORMAL: begin
          if (any_ev) begin
            state_r   <= ST_BLOCK;
            blk_cnt_r <= BLOCK_CYC - 32'h0000_0001;
          end
        end
        ST_BLOCK: begin
          if (any_ev) begin
            blk_cnt_r <= BLOCK_CYC - 32'h0000_0001;
          end else if (blk_exp) begin
            if (hold_cause) begin
              blk_cnt_r <= BLOCK_CYC - 32'h0000_0001;
            end else begin
              state_r <= ST_NORMAL;
            end
          end else begin
            blk_cnt_r <= blk_cnt_r - 32'h0000_0001;
          end
        end
        default: begin
          state_r <= ST_NORMAL;
        end
      endcase
    end
  end

  // manual close block timer runs beside the block timer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_cnt_r <= 32'h0000_0000;
    end else if (mc_rise & mc_en) begin
      mc_cnt_r <= mc_t_r;
    end else if (mc_running) begin
      mc_cnt_r <= mc_cnt_r - 32'h0000_0001;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_trip_d_r <= 1'b0;
      mc_d_r        <= 1'b0;
      pickup_d_r    <= 1'b0;
      rdy_d_r       <= 1'b0;
      dte_d_r       <= 1'b0;
      dynamic_block_flag      <= 1'b0;
      reclose_lockout_flag    <= 1'b0;
      breaker_fail_block_flag <= 1'b0;
      external_block_echo     <= 1'b0;
    end else begin
      prot_trip_d_r <= prot_trip;
      mc_d_r        <= manual_close_detect;
      pickup_d_r    <= prot_pickup;
      rdy_d_r       <= breaker_ready_input;
      dte_d_r       <= dead_time_end;
      // flag follows next state so it spans entry to resume
      dynamic_block_flag <= dyn_nxt;
      if (ev[`RCDB_EV_LOCK]) begin
        reclose_lockout_flag <= 1'b1;
      end else if (~dyn_nxt) begin
        reclose_lockout_flag <= 1'b0;
      end
      if (ev[`RCDB_EV_BF]) begin
        breaker_fail_block_flag <= 1'b1;
      end else if (~dyn_nxt) begin
        breaker_fail_block_flag <= 1'b0;
      end
      external_block_echo <= external_block_input;
    end
  end

  // register file; set wins over write-one-to-clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r     <= `RCDB_CTRL_RST;
      act_t_r    <= 32'h0000_0000;
      watch_t_r  <= 32'h0000_0000;
      ext_t_r    <= 32'h0000_0000;
      rdy_t_r    <= 32'h0000_0000;
      mc_t_r     <= 32'h0000_0000;
      ilim_r     <= 16'hffff;
      irq_mask_r <= {`RCDB_EV_W{1'b0}};
      irq_st_r   <= {`RCDB_EV_W{1'b0}};
    end else begin
      if (wr_en & addr_hit(paddr, `RCDB_A_CTRL))     ctrl_r     <= pwdata;
      if (wr_en & addr_hit(paddr, `RCDB_A_ACT_T))    act_t_r    <= pwdata;
      if (wr_en & addr_hit(paddr, `RCDB_A_WATCH_T))  watch_t_r  <= pwdata;
      if (wr_en & addr_hit(paddr, `RCDB_A_EXT_T))    ext_t_r    <= pwdata;
      if (wr_en & addr_hit(paddr, `RCDB_A_RDY_T))    rdy_t_r    <= pwdata;
      if (wr_en & addr_hit(paddr, `RCDB_A_MC_T))     mc_t_r     <= pwdata;
      if (wr_en & addr_hit(paddr, `RCDB_A_ILIM))     ilim_r     <= pwdata[15:0];
      if (wr_en & addr_hit(paddr, `RCDB_A_IRQ_MASK)) irq_mask_r <= pwdata[`RCDB_EV_W-1:0];
      irq_st_r <= (irq_st_r & ~((wr_en & addr_hit(paddr, `RCDB_A_IRQ_ST))
                  ? pwdata[`RCDB_EV_W-1:0] : {`RCDB_EV_W{1'b0}})) | ev;
    end
  end

  assign irq = |(irq_st_r & irq_mask_r);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      // captured in setup so data stands during the access cycle
      case ({2'b00, paddr[11:2]})
        `RCDB_A_CTRL     >> 2: prdata <= {30'h0, ctrl_r[1:0]};
        `RCDB_A_ACT_T    >> 2: prdata <= act_t_r;
        `RCDB_A_WATCH_T  >> 2: prdata <= watch_t_r;
        `RCDB_A_EXT_T    >> 2: prdata <= ext_t_r;
        `RCDB_A_RDY_T    >> 2: prdata <= rdy_t_r;
        `RCDB_A_MC_T     >> 2: prdata <= mc_t_r;
        `RCDB_A_ILIM     >> 2: prdata <= {16'h0, ilim_r};
        `RCDB_A_STAT     >> 2: prdata <= {27'h0, external_block_echo,
                                 breaker_fail_block_flag, reclose_lockout_flag,
                                 mc_running, dynamic_block_flag};
        `RCDB_A_IRQ_ST   >> 2: prdata <= {20'h0, irq_st_r};
        `RCDB_A_IRQ_MASK >> 2: prdata <= {20'h0, irq_mask_r};
        default:               prdata <= 32'h0000_0000;
      endcase
    end
  end

  wire unused_rd = rd_en;

endmodule

// ---- rcdb_top_checker.sv ----
// Purpose: port-level checks for the dynamic blocking supervisor
// Assumes: one clock, rst_n asynchronous active low
// Notes:   500 ms expiry is out of reach, so entry and hold are checked
`timescale 1ns/1ps
module rcdb_top_checker (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // apb
  input wire psel,
  input wire pready,
  input wire pslverr,
  // causes
  input wire external_block_input,
  input wire bf_trip,
  input wire thermal_ar_active,
  input wire other_prot_trip,
  input wire static_block,
  // indications
  input wire dynamic_block_flag,
  input wire reclose_lockout_flag,
  input wire breaker_fail_block_flag,
  input wire external_block_echo
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_entry;
    !dynamic_block_flag ##1 dynamic_block_flag;
  endsequence
  AST_APB_READY: assert property (psel |-> pready && !pslverr)
    else $error("apb access not answered at once");
  AST_EXT_BLOCK: assert property (external_block_input |=> dynamic_block_flag)
    else $error("external block input did not block");
  AST_EXT_ECHO: assert property (1'b1 |=> external_block_echo == $past(external_block_input))
    else $error("external block echo wrong");
  AST_BF_BLOCK: assert property (bf_trip |=> dynamic_block_flag && breaker_fail_block_flag)
    else $error("breaker failure trip did not block");
  AST_THERMAL: assert property (thermal_ar_active && other_prot_trip |=> dynamic_block_flag)
    else $error("trip during thermal reclose did not block");
  AST_HOLD: assert property (s_entry |=> dynamic_block_flag [*8])
    else $error("block dropped right after entry");
  AST_BF_FLAG: assert property (breaker_fail_block_flag |-> dynamic_block_flag)
    else $error("breaker failure flag outside block");
  AST_LOCK_FLAG: assert property (reclose_lockout_flag |-> dynamic_block_flag)
    else $error("lockout flag outside block");
  AST_STATIC_QUIET: assert property ($past(static_block) |-> !$rose(reclose_lockout_flag))
    else $error("indication under static block");
endmodule
bind rcdb_top rcdb_top_checker i_rcdb_top_checker (
  .clk(clk), .rst_n(rst_n), .psel(psel), .pready(pready), .pslverr(pslverr),
  .external_block_input(external_block_input), .bf_trip(bf_trip),
  .thermal_ar_active(thermal_ar_active), .other_prot_trip(other_prot_trip),
  .static_block(static_block), .dynamic_block_flag(dynamic_block_flag),
  .reclose_lockout_flag(reclose_lockout_flag),
  .breaker_fail_block_flag(breaker_fail_block_flag),
  .external_block_echo(external_block_echo)
);

// ---- rcdb_breaker.sv ----
// Purpose: breaker model facing the supervisor
// Assumes: trips are levels
// Notes:   slow breaker never opens and drops ready, to reach the watch paths
`timescale 1ns/1ps
module rcdb_breaker #(
  parameter OPEN_DLY = 3
) (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // control
  input  wire trip,
  input  wire slow,
  // breaker state
  output wire breaker_open,
  output wire breaker_closed,
  output wire breaker_ready_input
);
  reg [3:0] cnt_r;
  reg       open_r;
  assign breaker_open        = open_r;
  assign breaker_closed      = !open_r;
  assign breaker_ready_input = !slow;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 4'h0;
      open_r <= 1'b0;
    end else if (trip && !slow && !open_r) begin
      cnt_r  <= cnt_r + 4'h1;
      open_r <= (cnt_r == OPEN_DLY - 1);
    end
  end
endmodule

// ---- reclose_dynamic_blocking_bench.sv ----
// Purpose: self-checking bench for the dynamic blocking supervisor
// Assumes: timer settings of 10 cycles, current limit 0x100
// Notes:   block expiry takes 62.5M cycles, so each case starts from reset
`timescale 1ns/1ps
`include "rcdb_defs.vh"
module reclose_dynamic_blocking_bench;
  typedef struct packed {
    logic [15:0] drv;
    logic [7:0]  wt;
    logic [11:0] ev;
    logic [2:0]  fl;
  } rcdb_row_t;
  reg clk, rst_n, psel, penable, pwrite, slow, hi_cur, static_block;
  reg prot_pickup, prot_trip, bf_trip, thermal_ar_active, other_prot_trip, reverse_fault;
  reg external_block_input, manual_close_detect, seq_started, dead_time_end;
  reg in_dead_time, reclaim_running, reclaim_expired, cycles_exhausted;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, dynamic_block_flag, reclose_lockout_flag;
  wire breaker_fail_block_flag, external_block_echo, irq, b_open, b_closed, b_ready;
  wire [15:0] fault_current = hi_cur ? 16'h0100 : 16'h00ff;
  wire [31:0] flags_now = {29'h0, reclose_lockout_flag, breaker_fail_block_flag,
                           dynamic_block_flag};
  integer err_count, n_compared, i, k;
  rcdb_row_t rows [11];
  rcdb_top i_rcdb_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prot_pickup(prot_pickup), .prot_trip(prot_trip), .bf_trip(bf_trip),
    .thermal_ar_active(thermal_ar_active), .other_prot_trip(other_prot_trip),
    .reverse_fault(reverse_fault), .fault_current(fault_current), .breaker_open(b_open),
    .breaker_closed(b_closed), .breaker_ready_input(b_ready),
    .external_block_input(external_block_input), .manual_close_detect(manual_close_detect),
    .seq_started(seq_started), .dead_time_end(dead_time_end), .in_dead_time(in_dead_time),
    .reclaim_running(reclaim_running), .reclaim_expired(reclaim_expired),
    .cycles_exhausted(cycles_exhausted), .static_block(static_block),
    .dynamic_block_flag(dynamic_block_flag), .reclose_lockout_flag(reclose_lockout_flag),
    .breaker_fail_block_flag(breaker_fail_block_flag),
    .external_block_echo(external_block_echo), .irq(irq));
  rcdb_breaker i_rcdb_breaker (.clk(clk), .rst_n(rst_n),
    .trip(prot_trip | bf_trip | other_prot_trip), .slow(slow), .breaker_open(b_open),
    .breaker_closed(b_closed), .breaker_ready_input(b_ready));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
        err_count = err_count + 1;
        conclude;
      end
    end
  endtask
  task drive(input [15:0] d);
    {reclaim_expired, in_dead_time, reclaim_running, cycles_exhausted, slow, prot_trip,
     dead_time_end, hi_cur, manual_close_detect, seq_started, other_prot_trip,
     thermal_ar_active, reverse_fault, prot_pickup, bf_trip, external_block_input} <= d;
  endtask
  // prog=0 leaves settings at reset values, so manual close is off
  task restart(input prog);
    begin
      rst_n <= 1'b0;
      drive(16'h0);
      static_block <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      if (prog) begin
        apb(1, `RCDB_A_CTRL, 32'h3);
        for (k = 4; k <= 20; k = k + 4)
          apb(1, k[11:0], 32'ha);
        apb(1, `RCDB_A_ILIM, 32'h100);
        apb(1, `RCDB_A_IRQ_MASK, 32'hfff);
      end
    end
  endtask
  initial begin
    err_count = 0;
    n_compared = 0;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    static_block = 1'b0;
    rst_n = 1'b0;
    drive(16'h0);
    rows = '{'{16'h0001, 8'd2, 12'h800, 3'b001}, '{16'h0002, 8'd2, 12'h200, 3'b011},
      '{16'h000c, 8'd2, 12'h020, 3'b001}, '{16'h0030, 8'd2, 12'h080, 3'b001},
      '{16'h0140, 8'd2, 12'h040, 3'b001}, '{16'h0080, 8'd2, 12'h400, 3'b001},
      '{16'h0240, 8'd14, 12'h004, 3'b001}, '{16'h0c00, 8'd14, 12'h002, 3'b001},
      '{16'h4800, 8'd14, 12'h008, 3'b001}, '{16'h3400, 8'd4, 12'h100, 3'b101},
      '{16'h8400, 8'd8, 12'h010, 3'b001}};
    for (i = 0; i < 11; i = i + 1) begin
      restart(1);
      // dead time only follows a trip, so the breaker is opened first
      if (rows[i].drv[9]) begin
        drive(16'h0400);
        repeat (4) @(posedge clk);
      end
      drive(rows[i].drv);
      repeat (rows[i].wt) @(posedge clk);
      chk("flags", {29'h0, rows[i].fl}, flags_now);
      apb(0, `RCDB_A_IRQ_ST, 32'h0);
      chk("event", {20'h0, rows[i].ev}, rd & {20'h0, rows[i].ev});
      chk("irq", 32'h1, {31'h0, irq});
      $display("row %0d done", i);
    end
    restart(0);
    chk("flag", 32'h0, {31'h0, dynamic_block_flag});
    apb(0, `RCDB_A_ILIM, 32'h0);
    chk("ilim", 32'h0000ffff, rd);
    apb(1, 12'h030, 32'hffffffff);
    apb(0, 12'h030, 32'h0);
    chk("unmapped", 32'h0, rd);
    drive(16'h0080);
    repeat (3) @(posedge clk);
    chk("flag", 32'h0, {31'h0, dynamic_block_flag});
    drive(16'h0);
    static_block <= 1'b1;
    apb(1, `RCDB_A_MC_T, 32'ha);
    drive(16'h0080);
    repeat (2) @(posedge clk);
    chk("flag", 32'h1, {31'h0, dynamic_block_flag});
    $display("manual close done");
    restart(1);
    drive(16'h0001);
    repeat (2) @(posedge clk);
    drive(16'h0);
    apb(1, `RCDB_A_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1, `RCDB_A_IRQ_MASK, 32'hfff);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1, `RCDB_A_IRQ_ST, 32'hfff);
    apb(0, `RCDB_A_IRQ_ST, 32'h0);
    chk("status", 32'h0, rd);
    chk("irq", 32'h0, {31'h0, irq});
    $display("interrupt done");
    for (i = 0; i < 2; i = i + 1) begin
      restart(1);
      static_block <= (i == 0);
      drive(16'h0004);
      repeat (12) @(posedge clk);
      drive(16'h0404);
      repeat (2) @(posedge clk);
      chk("flag", i, {31'h0, dynamic_block_flag});
    end
    apb(0, `RCDB_A_IRQ_ST, 32'h0);
    chk("action", 32'h1, rd & 32'h1);
    $display("action time done");
    conclude;
  end
endmodule
